// ### rtl/mspsq_pkg.sv
/*
  Shared constants and types of the multi-segment playback sequencer.
  Assumes a single 20 MHz sample clock on the user side.
*/
package mspsq_pkg;

  // Table sizes
  localparam int NSEG_W = 3;
  localparam int NSEG   = 8;
  localparam int ROW_W  = 5;
  localparam int NROW   = 32;
  localparam int REP_W  = 8;
  localparam int LEN_W  = 16;
  localparam int NAME_W = 32;
  localparam int WORD_W = NSEG_W + LEN_W;

  // Output word fields
  localparam int WORD_SEG_LSB = LEN_W;
  localparam int WORD_OFF_LSB = 0;

  // Reset values
  localparam logic [NSEG_W-1:0] SEL_RST  = 3'h0;
  localparam logic [LEN_W-1:0]  LEN_RST  = 16'h0001;
  localparam logic [NAME_W-1:0] NAME_RST = 32'h0000_0000;

  // Timing: gap inserted on an abort-and-switch
  localparam int CLK_PERIOD_NS = 50;
  localparam int GAP_TIME_NS   = 1000;
  localparam int GAP_W         = 6;
  localparam int GAP_CYC_I     = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [GAP_W-1:0] GAP_CYC = GAP_W'(GAP_CYC_I < 1 ? 1 : GAP_CYC_I);

  // Switch-over policies
  typedef enum logic [1:0] {
    MODE_HOLD     = 2'h0,
    MODE_ABORT    = 2'h1,
    MODE_GAPLESS  = 2'h2,
    MODE_PLAYLIST = 2'h3
  } mspsq_mode_t;

  // Per-row actions
  typedef enum logic [1:0] {
    ACT_ADVANCE = 2'h0,
    ACT_BLANK   = 2'h1,
    ACT_ENDLESS = 2'h2,
    ACT_JUMP    = 2'h3
  } mspsq_act_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_PLAY  = 4'h2,
    ST_GAP   = 4'h4,
    ST_BLANK = 4'h8
  } mspsq_state_t;

  typedef struct packed {
    logic              en;
    mspsq_act_t        act;
    logic [NSEG_W-1:0] seg;
    logic [REP_W-1:0]  rep;
    logic [ROW_W-1:0]  jump;
  } mspsq_row_t;

endpackage

// ### rtl/mspsq_stream_if.sv
/*
  Valid/ready word stream between sequencer, buffer and the output port.
  Assumes both ends share one clock.
*/
`timescale 1ns/10ps
interface mspsq_stream_if;
  import mspsq_pkg::*;
  logic              valid;
  logic              ready;
  logic [WORD_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : mspsq_stream_if

// ### rtl/mspsq_buf.sv
/*
  Two-entry flip-flop buffer on the sample word path.
  Assumes a synchronous sink that may stall at any time.
*/
`timescale 1ns/10ps
module mspsq_buf
  import mspsq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Streams
  mspsq_stream_if.snk in_s,
  mspsq_stream_if.src out_s
);

  typedef struct packed {
    logic [1:0][WORD_W-1:0] mem;
    logic                   wp;
    logic                   rp;
    logic [1:0]             cnt;
  } mspsq_buf_t;

  mspsq_buf_t q;
  mspsq_buf_t d;
  logic       push;
  logic       pop;

  assign in_s.ready  = (q.cnt != 2'h2);
  assign out_s.valid = (q.cnt != 2'h0);
  assign out_s.data  = q.mem[q.rp];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_s.data;
      d.wp        = ~q.wp;
    end
    if (pop) begin
      d.rp = ~q.rp;
    end
    case ({push, pop})
      2'b10:   d.cnt = q.cnt + 2'h1;
      2'b01:   d.cnt = q.cnt - 2'h1;
      default: d.cnt = q.cnt;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule // mspsq_buf

// ### rtl/mspsq_top.sv
/*
  Segment sequencer: picks the segment and sample offset output next,
  from a play list or from switch triggers under four policies.
  Assumes host strobes and the trigger pin are synchronous-free inputs
  sampled on clk; sample words leave through a two-entry buffer.
*/
// Contract
// - Advance action moves to next enabled row after segment completes.
// - Blank action stops output after segment until restart arrives.
// - Restart while blanked restarts the play list from the beginning.
// - Endless action replays segment until restart, then restarts play list.
// - Stepping or restarting the play list skips disabled rows.
// - Jump action continues at the row given; targets limited to 32 rows.
// - Selected index names next segment and first segment on enable.
// - External trigger or a changing index write requests a switch.
// - Trigger during the last segment wraps to the first segment.
// - Hold policy ignores triggers; only an index change switches.
// - Abort policy stops at once and restarts after a fixed gap.
// - Gapless policy switches only at segment end, with no gap.
// - Play-list policy follows row order with per-row repeats.
// - Internal source switches to selected index on manual strobe.
// - External source takes switch events from the trigger pin.
// - Play-list policy ignores source selection and manual strobe.
// - Report index and name of the segment being output.
// - Each row carries a repeat count for its segment.
// - Each row carries an enable flag; cleared rows are not played.
`timescale 1ns/10ps
module mspsq_top
  import mspsq_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Playback control
  input  wire logic              play_en,
  input  wire mspsq_mode_t       mode,
  input  wire logic              src_ext,
  input  wire logic [NSEG_W-1:0] last_seg,
  input  wire logic              sel_wr,
  input  wire logic [NSEG_W-1:0] sel_wdata,
  input  wire logic              manual_strobe,
  input  wire logic              restart,
  input  wire logic              ext_trig,
  // Play-list row writes
  input  wire logic              row_wr,
  input  wire logic [ROW_W-1:0]  row_addr,
  input  wire mspsq_row_t        row_wdata,
  // Segment table writes
  input  wire logic              seg_wr,
  input  wire logic [NSEG_W-1:0] seg_addr,
  input  wire logic [LEN_W-1:0]  seg_len,
  input  wire logic [NAME_W-1:0] seg_name,
  // Status
  output logic [NSEG_W-1:0]      sel_index,
  output logic [NSEG_W-1:0]      cur_index,
  output logic [NAME_W-1:0]      cur_name,
  output logic                   blanked,
  output logic [ROW_W-1:0]       cur_row,
  // Sample word stream
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic [WORD_W-1:0]      out_data
);

  typedef struct packed {
    mspsq_state_t                 st;
    logic [NSEG_W-1:0]            cur;
    logic [NSEG_W-1:0]            pend;
    logic                         pend_v;
    logic [NSEG_W-1:0]            sel;
    logic [LEN_W-1:0]             off;
    logic [GAP_W-1:0]             gap;
    logic [ROW_W-1:0]             row;
    logic [REP_W-1:0]             rep;
    logic                         en_prev;
    logic [2:0]                   ext;
    logic [NAME_W-1:0]            name_out;
    logic [NROW-1:0][$bits(mspsq_row_t)-1:0] rows;
    logic [NSEG-1:0][LEN_W-1:0]   lens;
    logic [NSEG-1:0][NAME_W-1:0]  names;
  } mspsq_seq_t;

  // First enabled row at or after start, wrapping; bit ROW_W is found
  function automatic logic [ROW_W:0] find_row(
    input logic [NROW-1:0][$bits(mspsq_row_t)-1:0] rows,
    input logic [ROW_W-1:0]                        start
  );
    logic [ROW_W:0]   res;
    logic [ROW_W-1:0] idx;
    mspsq_row_t       r;
    res = '0;
    for (int i = NROW - 1; i >= 0; i--) begin
      idx = start + ROW_W'(i);
      r   = mspsq_row_t'(rows[idx]);
      if (r.en) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction

  mspsq_stream_if seq_s ();
  mspsq_stream_if buf_s ();

  mspsq_seq_t        q;
  mspsq_seq_t        d;
  mspsq_row_t        row_cur;
  logic              seg_end;
  logic              ext_edge;
  logic              trig;
  logic              sel_chg;
  logic              sw_ev;
  logic [NSEG_W-1:0] sw_tgt;
  logic              seq_load;
  logic [ROW_W-1:0]  seq_from;
  logic [ROW_W:0]    found;
  logic [LEN_W-1:0]  len_cur;
  logic              is_list;
  mspsq_row_t        row_nxt;

  assign row_cur  = mspsq_row_t'(q.rows[q.row]);
  assign len_cur  = (q.lens[q.cur] == '0) ? LEN_RST : q.lens[q.cur];
  assign is_list  = (mode == MODE_PLAYLIST);
  assign ext_edge = q.ext[1] & ~q.ext[2];
  assign seg_end  = (q.st == ST_PLAY) && seq_s.ready && (q.off == len_cur - LEN_W'(1));

  // Switch request decode outside the play list
  always_comb begin
    trig    = src_ext ? ext_edge : manual_strobe;
    sel_chg = sel_wr && (sel_wdata != q.sel);
    sw_ev   = 1'b0;
    sw_tgt  = q.sel;
    if (!is_list) begin
      if (mode == MODE_HOLD) begin
        sw_ev  = sel_chg;
        sw_tgt = sel_wdata;
      end else begin
        sw_ev = sel_chg | trig;
        if (sel_chg) begin
          sw_tgt = sel_wdata;
        end else if (src_ext) begin
          sw_tgt = (q.cur == last_seg) ? '0 : q.cur + NSEG_W'(1);
        end else begin
          sw_tgt = q.sel;
        end
      end
    end
  end

  // Sequencer offers a word in every play cycle
  assign seq_s.valid = (q.st == ST_PLAY);
  assign seq_s.data  = {q.cur, q.off};

  always_comb begin
    d        = q;
    seq_load = 1'b0;
    seq_from = '0;
    found    = '0;
    row_nxt  = '0;
    d.ext    = {q.ext[1:0], ext_trig};
    d.en_prev = play_en;
    d.name_out = q.names[q.cur];
    if (row_wr) begin
      d.rows[row_addr] = row_wdata;
    end
    if (seg_wr) begin
      d.lens[seg_addr]  = seg_len;
      d.names[seg_addr] = seg_name;
    end
    if (sel_wr) begin
      d.sel = sel_wdata;
    end
    if (seq_s.valid && seq_s.ready) begin
      d.off = seg_end ? '0 : q.off + LEN_W'(1);
    end

    if (!play_en) begin
      d.st     = ST_IDLE;
      d.pend_v = 1'b0;
    end else if (!q.en_prev) begin
      if (is_list) begin
        seq_load = 1'b1;
      end else begin
        d.cur = sel_wr ? sel_wdata : q.sel;
        d.off = '0;
        d.st  = ST_PLAY;
      end
    end else if (is_list) begin
      if (restart) begin
        seq_load = 1'b1;
      end else if (seg_end) begin
        if (q.rep + REP_W'(1) < ((row_cur.rep == '0) ? REP_W'(1) : row_cur.rep)) begin
          d.rep = q.rep + REP_W'(1);
        end else begin
          case (row_cur.act)
            ACT_ADVANCE: begin
              seq_load = 1'b1;
              seq_from = q.row + ROW_W'(1);
            end
            ACT_BLANK: begin
              d.st = ST_BLANK;
            end
            ACT_ENDLESS: begin
              d.rep = q.rep;
            end
            ACT_JUMP: begin
              seq_load = 1'b1;
              seq_from = row_cur.jump;
            end
            default: begin
              d.st = ST_BLANK;
            end
          endcase
        end
      end
    end else begin
      // Switch-request-driven policies
      case (q.st)
        ST_PLAY: begin
          if (mode == MODE_ABORT && sw_ev) begin
            d.cur = sw_tgt;
            d.off = '0;
            d.gap = GAP_CYC - GAP_W'(1);
            d.st  = ST_GAP;
            d.pend_v = 1'b0;
          end else if (seg_end && (sw_ev || q.pend_v)) begin
            d.cur    = sw_ev ? sw_tgt : q.pend;
            d.pend_v = 1'b0;
          end else if (sw_ev) begin
            d.pend   = sw_tgt;
            d.pend_v = 1'b1;
          end
        end
        ST_GAP: begin
          if (sw_ev) begin
            d.cur = sw_tgt;
            d.gap = GAP_CYC - GAP_W'(1);
          end else if (q.gap == '0) begin
            d.st = ST_PLAY;
          end else begin
            d.gap = q.gap - GAP_W'(1);
          end
        end
        ST_BLANK, ST_IDLE: begin
          d.cur = q.sel;
          d.off = '0;
          d.st  = ST_PLAY;
        end
        default: begin
          d.st = ST_IDLE;
        end
      endcase
    end

    // Enter a play-list row, skipping disabled ones
    if (seq_load) begin
      found = find_row(q.rows, seq_from);
      d.off = '0;
      d.rep = '0;
      if (found[ROW_W]) begin
        d.row = found[ROW_W-1:0];
        row_nxt = mspsq_row_t'(q.rows[found[ROW_W-1:0]]);
        d.cur   = row_nxt.seg;
        d.st  = ST_PLAY;
      end else begin
        d.st = ST_BLANK;
      end
    end
  end

  // Tables clear on reset: rows off, lengths of one sample
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q      <= '0;
      q.st   <= ST_IDLE;
      q.sel  <= SEL_RST;
      q.name_out <= NAME_RST;
    end else begin
      q <= d;
    end
  end

  // Two-word buffer so a sink stall loses no word
  mspsq_buf u_buf (
    .clk   (clk),
    .nrst  (nrst),
    .in_s  (seq_s.snk),
    .out_s (buf_s.src)
  );

  assign buf_s.ready = out_ready;
  assign out_valid   = buf_s.valid;
  assign out_data    = buf_s.data;
  assign sel_index   = q.sel;
  assign cur_index   = q.cur;
  assign cur_name    = q.name_out;
  assign blanked     = (q.st == ST_BLANK);
  assign cur_row     = q.row;

endmodule // mspsq_top

// ### test/mspsq_checker_assertions.sv
/* Port-level checks of the sequencer.
   Assumes one clock and the async low reset nrst. */
`timescale 1ns/10ps
module mspsq_checker
  import mspsq_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  // Control
  input wire logic              play_en,
  input wire mspsq_mode_t       mode,
  input wire logic              src_ext,
  input wire logic              sel_wr,
  input wire logic [NSEG_W-1:0] sel_wdata,
  input wire logic              manual_strobe,
  // Status and stream
  input wire logic [NSEG_W-1:0] sel_index,
  input wire logic [NSEG_W-1:0] cur_index,
  input wire logic              blanked,
  input wire logic              out_valid,
  input wire logic              out_ready,
  input wire logic [WORD_W-1:0] out_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic              acc;
  logic              have_q;
  logic [WORD_W-1:0] last_q;
  assign acc = out_valid && out_ready;
  wire [NSEG_W-1:0] w_seg = out_data[WORD_W-1:WORD_SEG_LSB];
  wire [LEN_W-1:0]  w_off = out_data[LEN_W-1:0];
  wire [NSEG_W-1:0] l_seg = last_q[WORD_W-1:WORD_SEG_LSB];
  wire [LEN_W-1:0]  l_off = last_q[LEN_W-1:0];
  // Last word taken by the sink
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      have_q <= 1'b0;
      last_q <= '0;
    end else if (acc) begin
      have_q <= 1'b1;
      last_q <= out_data;
    end
  end
  sequence s_abort;
    play_en && mode == MODE_ABORT && !src_ext && manual_strobe ##1 out_ready [*3];
  endsequence
  property p_sel_wr;
    sel_wr |=> sel_index == $past(sel_wdata);
  endproperty
  a_sel_wr: assert property (p_sel_wr) else $error("index not written");
  property p_sel_keep;
    !sel_wr |=> $stable(sel_index);
  endproperty
  a_sel_keep: assert property (p_sel_keep) else $error("index moved");
  property p_stall;
    out_valid && !out_ready |=> out_valid && $stable(out_data);
  endproperty
  a_stall: assert property (p_stall) else $error("word lost in stall");
  property p_strobe;
    play_en && $past(play_en) && mode == MODE_ABORT && !src_ext && manual_strobe && !sel_wr
      |=> cur_index == $past(sel_index);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe target wrong");
  property p_gap;
    s_abort |=> !out_valid [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("no gap after abort");
  property p_blank;
    (blanked && out_ready) [*3] |=> !out_valid;
  endproperty
  a_blank: assert property (p_blank) else $error("output while blank");
  property p_new_seg;
    acc && have_q && w_seg != l_seg |-> w_off == '0;
  endproperty
  a_new_seg: assert property (p_new_seg) else $error("segment not from start");
  property p_step;
    acc && have_q && w_seg == l_seg |-> w_off == LEN_W'(l_off + 1) || w_off == '0;
  endproperty
  a_step: assert property (p_step) else $error("offset skipped");
  c_abort: cover property (s_abort);
  c_blank: cover property (blanked);
  c_switch: cover property (acc && have_q && w_seg != l_seg);
endmodule // mspsq_checker

bind mspsq_top mspsq_checker chk_u (.*);

// ### test/mspsq_far.sv
/* Far side: word sink that can stall, and the external trigger source.
   Commands come from the bench on the rising edge. */
`timescale 1ns/10ps
module mspsq_far (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Commands
  input  wire logic stall,
  input  wire logic fire,
  // Pins toward the block
  output logic      out_ready,
  output logic      ext_trig
);
  logic [1:0] hi_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_ready <= 1'b0;
      hi_q      <= 2'h0;
    end else begin
      // Stall accepts only every other cycle
      out_ready <= stall ? !out_ready : 1'b1;
      hi_q      <= fire ? 2'h3 : hi_q - {1'b0, hi_q != 2'h0};
    end
  end
  // Trigger pin idles low; each fire is one pulse of three cycles
  assign ext_trig = (hi_q != 2'h0);
endmodule // mspsq_far

// ### test/mspsq_test.sv
/* Self-checking bench of the sequencer with the far-side model.
   Assumes segment length 4 for every segment. */
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module mspsq_test;
  import mspsq_pkg::*;
  logic              clk, nrst, play_en, src_ext, sel_wr, manual_strobe, restart;
  logic              row_wr, seg_wr, stall, fire, blanked, out_valid, out_ready, ext_trig;
  mspsq_mode_t       mode;
  logic [NSEG_W-1:0] last_seg, sel_wdata, seg_addr, sel_index, cur_index;
  logic [ROW_W-1:0]  row_addr, cur_row;
  mspsq_row_t        row_wdata;
  logic [LEN_W-1:0]  seg_len;
  logic [NAME_W-1:0] seg_name, cur_name;
  logic [WORD_W-1:0] out_data, w, p;
  int                n_errors, num_checks, cyc;
  time               t0;

  mspsq_top dut_u (.clk(clk), .nrst(nrst), .play_en(play_en), .mode(mode), .src_ext(src_ext),
    .last_seg(last_seg), .sel_wr(sel_wr), .sel_wdata(sel_wdata), .manual_strobe(manual_strobe),
    .restart(restart), .ext_trig(ext_trig), .row_wr(row_wr), .row_addr(row_addr),
    .row_wdata(row_wdata), .seg_wr(seg_wr), .seg_addr(seg_addr), .seg_len(seg_len),
    .seg_name(seg_name), .sel_index(sel_index), .cur_index(cur_index), .cur_name(cur_name),
    .blanked(blanked), .cur_row(cur_row), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data));
  mspsq_far far_u (.clk(clk), .nrst(nrst), .stall(stall), .fire(fire), .out_ready(out_ready),
    .ext_trig(ext_trig));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic strobe();
    @(posedge clk) manual_strobe <= 1'b1;
    @(posedge clk) manual_strobe <= 1'b0;
  endtask
  task automatic pulse_restart();
    @(posedge clk) restart <= 1'b1;
    @(posedge clk) restart <= 1'b0;
  endtask
  task automatic trig();
    @(posedge clk) fire <= 1'b1;
    @(posedge clk) fire <= 1'b0;
  endtask
  task automatic sel(input logic [NSEG_W-1:0] v);
    @(posedge clk) begin
      sel_wr    <= 1'b1;
      sel_wdata <= v;
    end
    @(posedge clk) sel_wr <= 1'b0;
  endtask
  task automatic row_wt(input logic [ROW_W-1:0] a, input mspsq_row_t r);
    @(posedge clk) begin
      row_wr    <= 1'b1;
      row_addr  <= a;
      row_wdata <= r;
    end
    @(posedge clk) row_wr <= 1'b0;
  endtask
  // Next word taken by the sink, sampled mid-cycle
  task automatic get_w();
    bit got;
    got = 0;
    for (int i = 0; i < 200 && !got; i++) begin
      @(negedge clk);
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
        w   = out_data;
        got = 1;
      end
    end
    `CHK(got, 1'b1)
    @(posedge clk);
  endtask
  task automatic wait_cur(input logic [NSEG_W-1:0] v);
    for (int i = 0; i < 40 && cur_index !== v; i++) @(negedge clk);
    `CHK(cur_index, v)
    @(posedge clk);
  endtask
  task automatic run_list(input int first, input int n);
    logic [NSEG_W-1:0] s;
    for (int i = first; i < n; i++) begin
      s = (i < 8) ? 3'h1 : (i < 12) ? 3'h2 : 3'h3;
      get_w();
      `CHK(w, {s, LEN_W'(i % 4)})
    end
  endtask

  task automatic t_gapless();
    mode    <= MODE_GAPLESS;
    stall   <= 1'b1;
    play_en <= 1'b1;
    get_w();
    `CHK(w, {3'h0, 16'h0000})
    sel(3'h3);
    p = w;
    for (int i = 0; i < 10 && w[WORD_W-1:WORD_SEG_LSB] === p[WORD_W-1:WORD_SEG_LSB]; i++) begin
      p = w;
      get_w();
    end
    `CHK(p[LEN_W-1:0], 16'h0003)
    `CHK(w, {3'h3, 16'h0000})
    tick(2);
    `CHK(cur_name, 32'h0000_0a03)
    stall <= 1'b0;
  endtask
  task automatic t_abort();
    mode <= MODE_ABORT;
    t0 = $time;
    sel(3'h5);
    for (int i = 0; i < 4 && w[WORD_W-1:WORD_SEG_LSB] !== 3'h5; i++) get_w();
    `CHK(w, {3'h5, 16'h0000})
    `CHK(($time - t0) >= 64'(GAP_CYC_I * CLK_PERIOD_NS), 1'b1)
    strobe();
    tick(30);
  endtask
  task automatic t_ext();
    sel(3'h1);
    wait_cur(3'h1);
    last_seg <= 3'h2;
    src_ext  <= 1'b1;
    trig();
    wait_cur(3'h2);
    trig();
    wait_cur(3'h0);
    trig();
    wait_cur(3'h1);
    trig();
    wait_cur(3'h2);
    src_ext <= 1'b0;
    strobe();
    wait_cur(3'h1);
    src_ext <= 1'b1;
  endtask
  task automatic t_hold();
    mode <= MODE_HOLD;
    trig();
    tick(30);
    `CHK(cur_index, 3'h1)
    src_ext <= 1'b0;
    sel(3'h2);
    wait_cur(3'h2);
  endtask
  task automatic t_list();
    play_en <= 1'b0;
    mode    <= MODE_PLAYLIST;
    row_wt(5'h00, '{1'b1, ACT_ADVANCE, 3'h1, 8'h02, 5'h00});
    row_wt(5'h01, '{1'b0, ACT_ADVANCE, 3'h7, 8'h01, 5'h00});
    row_wt(5'h02, '{1'b1, ACT_JUMP, 3'h2, 8'h01, 5'h04});
    row_wt(5'h03, '{1'b1, ACT_ADVANCE, 3'h6, 8'h01, 5'h00});
    row_wt(5'h04, '{1'b1, ACT_BLANK, 3'h3, 8'h01, 5'h00});
    @(posedge clk) play_en <= 1'b1;
    strobe();
    run_list(0, 16);
    tick(10);
    `CHK(blanked, 1'b1)
    row_wt(5'h04, '{1'b1, ACT_ENDLESS, 3'h3, 8'h01, 5'h00});
    pulse_restart();
    get_w();
    `CHK(w, {3'h1, 16'h0000})
    `CHK(cur_row, 5'h00)
    run_list(1, 24);
    pulse_restart();
    for (int i = 0; i < 4 && w[WORD_W-1:WORD_SEG_LSB] !== 3'h1; i++) get_w();
    `CHK(w, {3'h1, 16'h0000})
  endtask

  initial begin
    {nrst, play_en, src_ext, sel_wr, manual_strobe, restart, row_wr, seg_wr, stall, fire} = '0;
    mode      = MODE_HOLD;
    last_seg  = 3'h7;
    sel_wdata = 3'h0;
    seg_addr  = 3'h0;
    row_addr  = 5'h00;
    row_wdata = '0;
    seg_len   = 16'h0004;
    seg_name  = 32'h0000_0000;
    w         = '0;
    tick(4);
    nrst <= 1'b1;
    for (int i = 0; i < NSEG; i++) begin
      @(posedge clk) begin
        seg_wr   <= 1'b1;
        seg_addr <= NSEG_W'(i);
        seg_name <= 32'h0000_0a00 | NAME_W'(i);
      end
    end
    @(posedge clk) seg_wr <= 1'b0;
    t_gapless();
    t_abort();
    t_ext();
    t_hold();
    t_list();
    tally_and_finish();
  end
endmodule // mspsq_test
